// [hw/aatc_pkg.sv]
/*
 * constants, offsets, field positions and state type of the conversion
 * sequencing control; assumes a 32-bit AHB-Lite register bus and a 24-entry
 * channel index (0..15 low channels, 16..23 the eight high channels)
 */
package aatc_pkg;
	// channel index space
	localparam int unsigned NCH         = 24;
	localparam int unsigned CH_W        = 5;
	localparam int unsigned HIGH_BASE   = 16;
	localparam int unsigned ADD_GRP     = 8;
	localparam int unsigned TMR_G_NUM   = 4;
	localparam int unsigned CNT_W       = 2;
	localparam int unsigned ADDR_W      = 8;

	// register byte offsets
	localparam logic [7:0]  OFS_ADD_SEL_LO  = 8'h00;
	localparam logic [7:0]  OFS_ADD_SEL_HI  = 8'h04;
	localparam logic [7:0]  OFS_ADD_CNT_A   = 8'h08;
	localparam logic [7:0]  OFS_ADD_CNT_B   = 8'h0C;
	localparam logic [7:0]  OFS_EN_LO       = 8'h10;
	localparam logic [7:0]  OFS_EN_HI       = 8'h14;
	localparam logic [7:0]  OFS_SRC_LO      = 8'h18;
	localparam logic [7:0]  OFS_SRC_HI      = 8'h1C;
	localparam logic [7:0]  OFS_SOFT_LO     = 8'h20;
	localparam logic [7:0]  OFS_SOFT_HI     = 8'h24;
	localparam logic [7:0]  OFS_STATUS      = 8'h28;
	localparam logic [7:0]  OFS_SCAN_CTRL   = 8'h2C;
	localparam logic [7:0]  OFS_SCAN_MASK   = 8'h30;

	// field positions
	localparam int unsigned STAT_SCAN_BIT   = 7;
	localparam int unsigned STAT_INT_BIT    = 6;
	localparam int unsigned SCAN_GO_BIT     = 0;

	// reset values
	localparam logic [7:0]  RST_BYTE        = 8'h00;
	localparam logic [15:0] RST_HALF        = 16'h0000;
	localparam logic [1:0]  RST_CNT         = 2'h0;
	localparam logic [23:0] RST_MASK        = 24'h000000;

	// bus encodings
	localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
	localparam logic [31:0] RDATA_ZERO      = 32'h00000000;

	// sequencer states
	typedef enum logic [1:0] {
		AATC_SQ_IDLE,
		AATC_SQ_ISSUE,
		AATC_SQ_WAIT
	} aatc_seq_e;
endpackage : aatc_pkg

// [hw/aatc_ctrl.sv]
/*
 * addition-mode and interrupt-conversion sequencing for an a/d converter:
 * register file on AHB-Lite, trigger capture, scan with preemption and
 * result summing; assumes a conversion core on the same clock that answers
 * each conv_start pulse with one conv_done pulse and its sample
 */
// Register access over AHB-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - addition-select bit set: convert channel repeatedly, output the sum
// - addition-select bit clear: convert once, output that single result
// - addition choice applies equally to scan and interrupt conversions
// - addition available only on channels 0-7 and 40-47, two select regs
// - scan finishes all sums of a channel before moving to the next
// - interrupt request during scan halts scan, requested channel first
// - after interrupt conversion scan resumes on the interrupted channel
// - interrupted addition channel restarts from its first conversion
// - two-bit count: 00 one, 01 two, 10 three, 11 four conversions
// - count field ignored for channels without addition-select
// - count register bits 7..2 read zero, only bits 1..0 writable
// - per-channel enable accepts trigger requests when 1, ignores at 0
// - enabled channel is converted whenever its selected request arrives
// - timer group trigger k converts channel 40+k then 44+k
// - source 0 and enable 1: timer trigger edge starts conversion
// - source 1: writing 1 to software trigger bit starts conversion
// - select, count, enable and source registers reset to zero
// - scan-active reads 1 during a scan, 0 when idle
// - scan-active stays 1 through preemption until whole scan ends
// - one pending request per channel, repeats while pending ignored
module aatc_ctrl #(
	parameter int unsigned RES_W = 12
) (
	input  wire logic                         clk,
	input  wire logic                         rst_n,
	// AHB-Lite slave
	input  wire logic                         hsel,
	input  wire logic [31:0]                  haddr,
	input  wire logic [1:0]                   htrans,
	input  wire logic                         hwrite,
	input  wire logic [2:0]                   hsize,
	input  wire logic [31:0]                  hwdata,
	input  wire logic                         hready,
	output logic                              hreadyout,
	output logic                              hresp,
	output logic [31:0]                       hrdata,
	// timer triggers, asynchronous to clk
	input  wire logic [aatc_pkg::HIGH_BASE-1:0] tmr_d_trig,
	input  wire logic [aatc_pkg::TMR_G_NUM-1:0] tmr_g_trig,
	// conversion core
	output logic                              conv_start,
	output logic [aatc_pkg::CH_W-1:0]         conv_ch,
	input  wire logic                         conv_done,
	input  wire logic [RES_W-1:0]             conv_data,
	// result write toward the data registers
	output logic                              res_valid,
	output logic [aatc_pkg::CH_W-1:0]         res_ch,
	output logic                              res_is_int,
	output logic [RES_W+1:0]                  res_sum,
	// status
	output logic                              scan_active,
	output logic                              intconv_active
);
	import aatc_pkg::*;

	localparam int unsigned SUM_W = RES_W + 2; // four samples fit

	// refuse widths the sum path cannot carry
	generate
		if (RES_W < 1 || RES_W > 30)
		begin : g_bad_width
			$error("aatc_ctrl: RES_W must be 1..30");
		end
	endgenerate

	// lowest set bit at or above start, msb of result is the found flag
	function automatic logic [CH_W:0] find_next(input logic [NCH-1:0] m,
			input logic [CH_W-1:0] start);
		logic [CH_W:0] r;
		r = '0;
		for (int i = NCH - 1; i >= 0; i--)
		begin
			if (m[i] && (i >= int'(start)))
			begin
				r = {1'b1, CH_W'(i)};
			end
		end
		return r;
	endfunction : find_next

	// configuration registers
	logic [7:0]          add_sel_lo_reg;
	logic [7:0]          add_sel_hi_reg;
	logic [CNT_W-1:0]    add_cnt_a_reg;
	logic [CNT_W-1:0]    add_cnt_b_reg;
	logic [15:0]         en_lo_reg;
	logic [7:0]          en_hi_reg;
	logic [15:0]         src_lo_reg;
	logic [7:0]          src_hi_reg;
	logic [NCH-1:0]      scan_mask_reg;

	// bus data-phase state
	logic                dph_wr_reg;
	logic [ADDR_W-1:0]   dph_addr_reg;
	logic                wr_en;
	logic                soft_lo_wr;
	logic                soft_hi_wr;
	logic                scan_go;

	// trigger capture
	logic [HIGH_BASE+TMR_G_NUM-1:0] trg_s1_reg;
	logic [HIGH_BASE+TMR_G_NUM-1:0] trg_s2_reg;
	logic [HIGH_BASE+TMR_G_NUM-1:0] trg_s3_reg;
	logic [HIGH_BASE+TMR_G_NUM-1:0] trg_lvl_reg;
	logic [HIGH_BASE+TMR_G_NUM-1:0] trg_rise;

	// per-channel request handling
	logic [NCH-1:0]      en_all;
	logic [NCH-1:0]      src_all;
	logic [NCH-1:0]      add_all;
	logic [NCH-1:0]      soft_evt;
	logic [NCH-1:0]      tmr_evt;
	logic [NCH-1:0]      pend_reg;
	logic [NCH-1:0]      pend_clr;

	// sequencer
	aatc_seq_e           state_reg;
	logic [CH_W-1:0]     cur_ch_reg;
	logic                cur_int_reg;
	logic [CNT_W-1:0]    pass_reg;
	logic [SUM_W-1:0]    acc_reg;
	logic [CH_W-1:0]     scan_idx_reg;
	logic [CH_W:0]       int_pick;
	logic [CH_W:0]       scan_first;
	logic [CH_W:0]       scan_after;
	logic [CNT_W-1:0]    pass_need;
	logic [SUM_W-1:0]    sum_now;

	assign en_all  = {en_hi_reg, en_lo_reg};
	assign src_all = {src_hi_reg, src_lo_reg};
	assign add_all = {add_sel_hi_reg, 8'h00, add_sel_lo_reg};

	// bus write strobes, taken in the data phase
	assign wr_en      = dph_wr_reg;
	assign soft_lo_wr = wr_en && (dph_addr_reg == OFS_SOFT_LO);
	assign soft_hi_wr = wr_en && (dph_addr_reg == OFS_SOFT_HI);
	assign scan_go    = wr_en && (dph_addr_reg == OFS_SCAN_CTRL) && hwdata[SCAN_GO_BIT];

	// address phase capture and read data, zero wait states
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dph_wr_reg   <= 1'b0;
			dph_addr_reg <= '0;
			hrdata       <= RDATA_ZERO;
			hreadyout    <= 1'b0;
			hresp        <= 1'b0;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0; // always OKAY
			dph_wr_reg <= hsel && hready && (htrans == HTRANS_NONSEQ) && hwrite;
			dph_addr_reg <= haddr[ADDR_W-1:0];
			if (hsel && hready && (htrans == HTRANS_NONSEQ) && !hwrite)
			begin
				case (haddr[ADDR_W-1:0])
					OFS_ADD_SEL_LO: hrdata <= {24'h000000, add_sel_lo_reg};
					OFS_ADD_SEL_HI: hrdata <= {24'h000000, add_sel_hi_reg};
					OFS_ADD_CNT_A:  hrdata <= {30'h00000000, add_cnt_a_reg};
					OFS_ADD_CNT_B:  hrdata <= {30'h00000000, add_cnt_b_reg};
					OFS_EN_LO:      hrdata <= {16'h0000, en_lo_reg};
					OFS_EN_HI:      hrdata <= {24'h000000, en_hi_reg};
					OFS_SRC_LO:     hrdata <= {16'h0000, src_lo_reg};
					OFS_SRC_HI:     hrdata <= {24'h000000, src_hi_reg};
					OFS_STATUS:     hrdata <= {24'h000000, scan_active, intconv_active, 6'h00};
					OFS_SCAN_MASK:  hrdata <= {8'h00, scan_mask_reg};
					default:        hrdata <= RDATA_ZERO; // soft triggers, scan control and unmapped
				endcase
			end
			else
			begin
				hrdata <= RDATA_ZERO;
			end
		end
	end

	// configuration register writes
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			add_sel_lo_reg <= RST_BYTE;
			add_sel_hi_reg <= RST_BYTE;
			add_cnt_a_reg  <= RST_CNT;
			add_cnt_b_reg  <= RST_CNT;
			en_lo_reg      <= RST_HALF;
			en_hi_reg      <= RST_BYTE;
			src_lo_reg     <= RST_HALF;
			src_hi_reg     <= RST_BYTE;
			scan_mask_reg  <= RST_MASK;
		end
		else if (wr_en)
		begin
			case (dph_addr_reg)
				OFS_ADD_SEL_LO: add_sel_lo_reg <= hwdata[7:0];
				OFS_ADD_SEL_HI: add_sel_hi_reg <= hwdata[7:0];
				OFS_ADD_CNT_A:  add_cnt_a_reg  <= hwdata[CNT_W-1:0];
				OFS_ADD_CNT_B:  add_cnt_b_reg  <= hwdata[CNT_W-1:0];
				OFS_EN_LO:      en_lo_reg      <= hwdata[15:0];
				OFS_EN_HI:      en_hi_reg      <= hwdata[7:0];
				OFS_SRC_LO:     src_lo_reg     <= hwdata[15:0];
				OFS_SRC_HI:     src_hi_reg     <= hwdata[7:0];
				OFS_SCAN_MASK:  scan_mask_reg  <= hwdata[NCH-1:0];
				default:        ;
			endcase
		end
	end

	// three-stage capture of timer triggers; level moves once stages 2 and 3 agree
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			trg_s1_reg  <= '0;
			trg_s2_reg  <= '0;
			trg_s3_reg  <= '0;
			trg_lvl_reg <= '0;
		end
		else
		begin
			trg_s1_reg <= {tmr_g_trig, tmr_d_trig};
			trg_s2_reg <= trg_s1_reg;
			trg_s3_reg <= trg_s2_reg;
			for (int i = 0; i < HIGH_BASE + TMR_G_NUM; i++)
			begin
				if (trg_s2_reg[i] == trg_s3_reg[i])
				begin
					trg_lvl_reg[i] <= trg_s3_reg[i];
				end
			end
		end
	end

	// one rising edge event per settled low-to-high change
	assign trg_rise = trg_s2_reg & trg_s3_reg & ~trg_lvl_reg;

	// per-channel request sources and pending flags
	genvar gc;
	generate
		for (gc = 0; gc < NCH; gc++)
		begin : g_ch
			if (gc < HIGH_BASE)
			begin : g_lo
				assign tmr_evt[gc]  = trg_rise[gc];
				assign soft_evt[gc] = soft_lo_wr && hwdata[gc];
			end
			else
			begin : g_hi
				// group trigger k feeds both 40+k and 44+k
				assign tmr_evt[gc]  = trg_rise[HIGH_BASE + ((gc - HIGH_BASE) % TMR_G_NUM)];
				assign soft_evt[gc] = soft_hi_wr && hwdata[gc - HIGH_BASE];
			end

			// set wins over the completion clear; a repeat while pending merges
			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					pend_reg[gc] <= 1'b0;
				end
				else if (en_all[gc] && (src_all[gc] ? soft_evt[gc] : tmr_evt[gc]))
				begin
					pend_reg[gc] <= 1'b1;
				end
				else if (pend_clr[gc])
				begin
					pend_reg[gc] <= 1'b0;
				end
			end
		end
	endgenerate

	// lowest pending channel is served first, so 40+k runs before 44+k
	assign int_pick   = find_next(pend_reg, '0);
	assign scan_first = find_next(scan_mask_reg, '0);
	assign scan_after = (scan_idx_reg == CH_W'(NCH - 1)) ? '0 :
		find_next(scan_mask_reg, scan_idx_reg + 1'b1);

	// conversions for the current channel, less one
	assign pass_need = add_all[cur_ch_reg] ?
		((cur_ch_reg >= CH_W'(HIGH_BASE)) ? add_cnt_b_reg : add_cnt_a_reg) : '0;
	assign sum_now = acc_reg + SUM_W'(conv_data);

	// clear a channel's pending flag when its interrupt conversion completes
	always_comb
	begin
		pend_clr = '0;
		if ((state_reg == AATC_SQ_WAIT) && conv_done && cur_int_reg && (pass_reg == pass_need))
		begin
			pend_clr[cur_ch_reg] = 1'b1;
		end
	end

	// conversion sequencer with scan walk and preemption
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg    <= AATC_SQ_IDLE;
			cur_ch_reg   <= '0;
			cur_int_reg  <= 1'b0;
			pass_reg     <= '0;
			acc_reg      <= '0;
			scan_idx_reg <= '0;
			scan_active  <= 1'b0;
			conv_start   <= 1'b0;
			conv_ch      <= '0;
			res_valid    <= 1'b0;
			res_ch       <= '0;
			res_is_int   <= 1'b0;
			res_sum      <= '0;
		end
		else
		begin
			conv_start <= 1'b0;
			res_valid  <= 1'b0;
			if (scan_go && !scan_active && scan_first[CH_W])
			begin
				scan_active  <= 1'b1;
				scan_idx_reg <= scan_first[CH_W-1:0];
			end
			case (state_reg)
				AATC_SQ_IDLE:
				begin
					pass_reg <= '0;
					acc_reg  <= '0;
					if (int_pick[CH_W])
					begin
						cur_ch_reg  <= int_pick[CH_W-1:0];
						cur_int_reg <= 1'b1;
						state_reg   <= AATC_SQ_ISSUE;
					end
					else if (scan_active)
					begin
						cur_ch_reg  <= scan_idx_reg;
						cur_int_reg <= 1'b0;
						state_reg   <= AATC_SQ_ISSUE;
					end
				end
				AATC_SQ_ISSUE:
				begin
					conv_start <= 1'b1;
					conv_ch    <= cur_ch_reg;
					state_reg  <= AATC_SQ_WAIT;
				end
				AATC_SQ_WAIT:
				begin
					if (conv_done)
					begin
						if (!cur_int_reg && int_pick[CH_W])
						begin
							// drop partial sum; scan index stays put
							state_reg <= AATC_SQ_IDLE;
						end
						else if (pass_reg != pass_need)
						begin
							acc_reg   <= sum_now;
							pass_reg  <= pass_reg + 1'b1;
							state_reg <= AATC_SQ_ISSUE;
						end
						else
						begin
							res_valid  <= 1'b1;
							res_ch     <= cur_ch_reg;
							res_is_int <= cur_int_reg;
							res_sum    <= sum_now;
							state_reg  <= AATC_SQ_IDLE;
							if (!cur_int_reg)
							begin
								if (scan_after[CH_W])
								begin
									scan_idx_reg <= scan_after[CH_W-1:0];
								end
								else
								begin
									scan_active <= 1'b0;
								end
							end
						end
					end
				end
				default:
				begin
					state_reg <= AATC_SQ_IDLE;
				end
			endcase
		end
	end

	// interrupt-conversion status: any request pending or one in progress
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			intconv_active <= 1'b0;
		end
		else
		begin
			intconv_active <= (|pend_reg) || ((state_reg != AATC_SQ_IDLE) && cur_int_reg);
		end
	end
endmodule : aatc_ctrl

`default_nettype wire

// [sim/aatc_ctrl_properties.sv]
/*
 * port checker for the conversion sequencing control
 * assumes a single clk domain and bus ready tied to hreadyout
 */
`timescale 1ns/1ps
`default_nettype none
module aatc_ctrl_chk
	import aatc_pkg::*;
#(
	parameter int unsigned RES_W = 12
) (
	input wire logic              clk,
	input wire logic              rst_n,
	input wire logic              hsel,
	input wire logic [31:0]       haddr,
	input wire logic [1:0]        htrans,
	input wire logic              hwrite,
	input wire logic              hready,
	input wire logic              hreadyout,
	input wire logic              hresp,
	input wire logic [31:0]       hrdata,
	input wire logic              conv_start,
	input wire logic [CH_W-1:0]   conv_ch,
	input wire logic              conv_done,
	input wire logic              res_valid,
	input wire logic              res_is_int,
	input wire logic [RES_W+1:0]  res_sum,
	input wire logic              scan_active
);
	localparam logic [RES_W+1:0] SUM_MAX = {{RES_W{1'b1}}, 2'h0};
	logic busy_reg;
	logic rd_req;
	// read address phase accepted by the slave
	assign rd_req = hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// one conversion outstanding at the core
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			busy_reg <= 1'b0;
		else if (conv_start)
			busy_reg <= 1'b1;
		else if (conv_done)
			busy_reg <= 1'b0;
	end
	a_bus_okay: assert property ($past(rst_n) |-> hreadyout && !hresp)
		else $error("bus not ready or not okay");
	a_one_outstanding: assert property (conv_start |-> !busy_reg)
		else $error("second conversion started while one is running");
	a_start_pulse: assert property (conv_start |=> !conv_start)
		else $error("conversion start longer than one cycle");
	a_res_cause: assert property (res_valid |-> $past(conv_done) && $past(busy_reg))
		else $error("result without a preceding conversion end");
	a_ch_stable: assert property (!conv_start |-> $stable(conv_ch))
		else $error("conversion channel moved between starts");
	a_rdata_idle: assert property (!$past(rd_req) |-> hrdata == RDATA_ZERO)
		else $error("read data outside a read data phase");
	a_cnt_rsvd: assert property ($past(rd_req && (haddr[7:0] == OFS_ADD_CNT_A
		|| haddr[7:0] == OFS_ADD_CNT_B)) |-> hrdata[31:2] == 30'h0)
		else $error("count register reserved bits not zero");
	a_scan_end: assert property ($fell(scan_active) |-> res_valid && !res_is_int)
		else $error("scan active fell without final scan result");
	a_sum_limit: assert property (res_valid |-> res_sum <= SUM_MAX)
		else $error("summed result above four full-scale samples");
endmodule : aatc_ctrl_chk
bind aatc_ctrl aatc_ctrl_chk #(.RES_W(RES_W)) u_chk (.clk(clk), .rst_n(rst_n), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
	.hresp(hresp), .hrdata(hrdata), .conv_start(conv_start), .conv_ch(conv_ch),
	.conv_done(conv_done), .res_valid(res_valid), .res_is_int(res_is_int),
	.res_sum(res_sum), .scan_active(scan_active));
`default_nettype wire

// [sim/aatc_core_model.sv]
/*
 * behavioural analog conversion core: answers each start with one done
 * after lat cycles and a full-scale sample; assumes the clk of the control
 */
`timescale 1ns/1ps
`default_nettype none
module aatc_core_model #(
	parameter int unsigned RES_W = 12
) (
	input wire logic         clk,
	input wire logic         rst_n,
	input wire logic [3:0]   lat,
	input wire logic         conv_start,
	output logic             conv_done,
	output var logic [RES_W-1:0] conv_data
);
	logic [3:0]       cnt_reg;
	logic             busy_reg;
	logic [RES_W-1:0] junk_reg;
	// conversion timer, latency chosen by the bench
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			busy_reg <= 1'b0;
			cnt_reg <= 4'h0;
			junk_reg <= '0;
		end
		else
		begin
			junk_reg <= junk_reg + 1'b1;
			if (conv_start)
			begin
				busy_reg <= 1'b1;
				cnt_reg <= lat;
			end
			else if (busy_reg)
			begin
				if (cnt_reg == 4'h0)
					busy_reg <= 1'b0;
				else
					cnt_reg <= cnt_reg - 4'h1;
			end
		end
	end
	// sample only valid with done, a moving pattern otherwise
	assign conv_done = busy_reg && cnt_reg == 4'h0;
	assign conv_data = conv_done ? '1 : junk_reg;
endmodule : aatc_core_model
`default_nettype wire

// [sim/tb.sv]
/*
 * self-checking bench: AHB-Lite register access, timer and software
 * triggers, scan with preemption; assumes the core model beside the dut
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
	import aatc_pkg::*;
	localparam logic [13:0] FS = 14'h0FFF;
	logic clk, rst_n, hsel, hwrite, hreadyout, hresp, conv_start, conv_done;
	logic res_valid, res_is_int, scan_active, intconv_active;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [15:0] tmr_d;
	logic [3:0] tmr_g, lat;
	logic [4:0] conv_ch, res_ch;
	logic [11:0] conv_data;
	logic [13:0] res_sum;
	logic [19:0] resq[$];
	int error_cnt, checked;
	aatc_ctrl i_dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .tmr_d_trig(tmr_d),
		.tmr_g_trig(tmr_g), .conv_start(conv_start), .conv_ch(conv_ch),
		.conv_done(conv_done), .conv_data(conv_data), .res_valid(res_valid),
		.res_ch(res_ch), .res_is_int(res_is_int), .res_sum(res_sum),
		.scan_active(scan_active), .intconv_active(intconv_active));
	aatc_core_model i_core (.clk(clk), .rst_n(rst_n), .lat(lat), .conv_start(conv_start),
		.conv_done(conv_done), .conv_data(conv_data));
	// result collector, sampled mid-cycle
	always @(negedge clk)
		if (res_valid === 1'b1)
			resq.push_back({res_is_int, res_ch, res_sum});
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic end_sim;
		if (error_cnt == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_sim
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// one bus phase: hold until hready seen high, grab read data at that edge
	task automatic phase(output logic [31:0] q);
		logic r;
		do
		begin
			@(negedge clk);
			r = hreadyout;
			q = hrdata;
			@(posedge clk);
		end
		while (r !== 1'b1);
	endtask : phase
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= HTRANS_NONSEQ;
		phase(q);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		phase(q);
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask : rdchk
	task automatic expres(input logic i, input logic [4:0] ch, input logic [13:0] s);
		int n;
		n = 0;
		while (resq.size() == 0 && n < 2000)
		begin
			@(posedge clk);
			n++;
		end
		chk(resq.size() > 0 ? {12'h0, resq.pop_front()} : 32'hFFFFFFFF, {12'h0, i, ch, s});
	endtask : expres
	// watchdog
	initial
	begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		$display("[ERR] %0t watchdog expired", $time);
		end_sim();
	end
	// main sequence
	initial
	begin
		rst_n = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		tmr_d = 16'h0;
		tmr_g = 4'h0;
		lat = 4'h3;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 8; i++) rdchk(8'(4 * i), 32'h0);
		rdchk(8'h40, 32'h0);
		wr(OFS_ADD_CNT_B, 32'hFFFFFFFF);
		rdchk(OFS_ADD_CNT_B, 32'h3);
		// ch0 add mode on soft trigger, ch1 timer, ch2 soft; all idle here
		wr(OFS_ADD_SEL_LO, 32'h1);
		wr(OFS_EN_LO, 32'h7);
		wr(OFS_SRC_LO, 32'h5);
		for (int c = 0; c < 4; c++)
		begin
			wr(OFS_ADD_CNT_A, 32'(c));
			wr(OFS_SOFT_LO, 32'h1);
			expres(1'b1, 5'd0, 14'(FS * (c + 1)));
		end
		wr(OFS_ADD_SEL_LO, 32'h0);
		wr(OFS_SOFT_LO, 32'h1);
		expres(1'b1, 5'd0, FS);
		// repeat while pending and a disabled channel give nothing extra
		lat <= 4'hF;
		wr(OFS_SOFT_LO, 32'hC);
		wr(OFS_SOFT_LO, 32'h4);
		expres(1'b1, 5'd2, FS);
		lat <= 4'h3;
		tmr_d <= 16'h0002;
		expres(1'b1, 5'd1, FS);
		tmr_g <= 4'h1;
		wr(OFS_EN_HI, 32'h11);
		tmr_g <= 4'h0;
		@(posedge clk);
		tmr_g <= 4'h1;
		expres(1'b1, 5'd16, FS);
		expres(1'b1, 5'd20, FS);
		// scan of 40 and 41, 40 summed four times, preempted by ch2
		wr(OFS_ADD_SEL_HI, 32'h1);
		wr(OFS_ADD_CNT_B, 32'h3);
		wr(OFS_SCAN_MASK, 32'h30000);
		lat <= 4'h4;
		wr(OFS_SCAN_CTRL, 32'h1);
		wr(OFS_SOFT_LO, 32'h4);
		expres(1'b1, 5'd2, FS);
		expres(1'b0, 5'd16, 14'(FS * 4));
		expres(1'b0, 5'd17, FS);
		repeat (60) @(posedge clk);
		chk(32'(resq.size()), 32'h0);
		rdchk(OFS_STATUS, 32'h0);
		end_sim();
	end
endmodule : tb
`default_nettype wire
